// ==== hw/i2cfol_buf2.sv ====
// two-entry valid/ready buffer for received write bytes
// assumes one clock domain; head register feeds the output directly
`timescale 1ns/1ps
`default_nettype none
module i2cfol_buf2
	import i2cfol_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// fill side
	input wire logic in_valid_i,
	input wire i2cfol_rx_t in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output i2cfol_rx_t out_data_o,
	input wire logic out_ready_i
);

	i2cfol_rx_t head_q;
	i2cfol_rx_t tail_q;
	logic head_vld_q;
	logic tail_vld_q;
	logic push;
	logic pop;

	assign in_ready_o = ~tail_vld_q;
	assign out_valid_o = head_vld_q;
	assign out_data_o = head_q;
	assign push = in_valid_i & ~tail_vld_q;
	assign pop = head_vld_q & out_ready_i;

	// ==========================================================
	// storage
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			head_q <= '0;
			tail_q <= '0;
			head_vld_q <= 1'b0;
			tail_vld_q <= 1'b0;
		end
		else if (pop && tail_vld_q)
		begin
			head_q <= tail_q;
			tail_vld_q <= push;
			if (push)
			begin
				tail_q <= in_data_i;
			end
		end
		else if (pop)
		begin
			head_vld_q <= push;
			if (push)
			begin
				head_q <= in_data_i;
			end
		end
		else if (push && !head_vld_q)
		begin
			head_q <= in_data_i;
			head_vld_q <= 1'b1;
		end
		else if (push)
		begin
			tail_q <= in_data_i;
			tail_vld_q <= 1'b1;
		end
	end

endmodule : i2cfol_buf2
`default_nettype wire

// ==== hw/i2cfol_pkg.sv ====
// i2c follower front end: shared constants, types and state codes
// assumes a 100 MHz core clock; bus pins arrive asynchronously
package i2cfol_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STD_RATE_KBPS = 100;
	localparam int FAST_RATE_KBPS = 400;
	localparam int SPIKE_NS = 50;
	// spike width rounded up to whole cycles; a level must outlast it
	localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] FILT_CNT = 3'(FILT_CYC);
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ==========================================================
	// addressing
	localparam logic [3:0] BASE_ADDR = 4'h8;
	localparam logic [7:0] ID_WR_BYTE = 8'hf8;
	localparam logic [7:0] ID_RD_BYTE = 8'hf9;
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_FLOAT = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;
	localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
	localparam logic [3:0] BIT_CNT_ACKED = 4'h9;

	// ==========================================================
	// identity word (field values arbitrary)
	localparam logic [11:0] ID_MAKER = 12'h5a3;
	localparam logic [8:0] ID_PART = 9'h0c6;
	localparam logic [2:0] ID_REV = 3'h1;
	localparam logic [23:0] ID_WORD = {ID_MAKER, ID_PART, ID_REV};
	localparam logic [1:0] ID_LAST_IDX = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_MACK = 3'b100
	} i2cfol_state_t;

	typedef enum logic [1:0] {
		K_ADDR = 2'b00,
		K_IDSEL = 2'b01,
		K_DATA = 2'b10
	} i2cfol_kind_t;

	typedef struct packed {
		logic first;
		logic [7:0] data;
	} i2cfol_rx_t;

endpackage : i2cfol_pkg

// ==== hw/i2cfol_top.sv ====
// i2c follower front end: strap address decode, byte engine, identity read
// assumes scl/sda/strap pins are asynchronous; sda is open drain
`timescale 1ns/1ps
`default_nettype none

module i2cfol_top
	import i2cfol_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// address straps, ternary code per pin
	input wire logic [1:0] addr_strap_low_pin_i,
	input wire logic [1:0] addr_strap_high_pin_i,
	// bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	// mode
	output logic spi_mode_o,
	output logic [6:0] own_addr_o,
	// received write bytes
	output i2cfol_rx_t rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	// read data for the leader
	output logic rd_req_o,
	input wire logic [7:0] rd_data_i
);

	// ==========================================================
	// helpers
	function automatic logic [3:0] strap_digit(input logic [1:0] s);
		if (s == STRAP_LOW)
			strap_digit = 4'h0;
		else if (s == STRAP_HIGH)
			strap_digit = 4'h2;
		else
			strap_digit = 4'h1;
	endfunction : strap_digit

	function automatic logic [7:0] id_byte(input logic [1:0] idx);
		if (idx == 2'h0)
			id_byte = ID_WORD[23:16];
		else if (idx == 2'h1)
			id_byte = ID_WORD[15:8];
		else
			id_byte = ID_WORD[7:0];
	endfunction : id_byte

	// ==========================================================
	// synchronisers and spike filter
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic [1:0] filt_q;
	logic [1:0] prev_q;
	logic [2:0] fcnt_q [2];
	logic [3:0] strap_s1_q;
	logic [3:0] strap_s2_q;

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			pin_s1_q <= 2'h3;
			pin_s2_q <= 2'h3;
			strap_s1_q <= 4'h0;
			strap_s2_q <= 4'h0;
		end
		else
		begin
			pin_s1_q <= {sda_i, scl_i};
			pin_s2_q <= pin_s1_q;
			strap_s1_q <= {addr_strap_high_pin_i, addr_strap_low_pin_i};
			strap_s2_q <= strap_s1_q;
		end
	end

	// a change is accepted only after it outlasts the spike width
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			filt_q <= 2'h3;
			prev_q <= 2'h3;
			fcnt_q[0] <= 3'h0;
			fcnt_q[1] <= 3'h0;
		end
		else
		begin
			prev_q <= filt_q;
			for (int i = 0; i < 2; i++)
			begin
				if (pin_s2_q[i] == filt_q[i])
					fcnt_q[i] <= 3'h0;
				else if (fcnt_q[i] == FILT_CNT)
				begin
					filt_q[i] <= pin_s2_q[i];
					fcnt_q[i] <= 3'h0;
				end
				else
					fcnt_q[i] <= fcnt_q[i] + 3'h1;
			end
		end
	end

	logic scl_f;
	logic sda_f;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_f = filt_q[0];
	assign sda_f = filt_q[1];
	assign scl_rise = scl_f & ~prev_q[0];
	assign scl_fall = ~scl_f & prev_q[0];
	assign bus_start = scl_f & prev_q[0] & prev_q[1] & ~sda_f;
	assign bus_stop = scl_f & prev_q[0] & ~prev_q[1] & sda_f;

	// ==========================================================
	// strap capture after reset release
	logic [1:0] settle_q;
	logic cap_done_q;
	logic spi_mode_q;
	logic [6:0] own_addr_q;
	logic [3:0] strap_idx;

	// ternary index high*3+low; index 0 is both low
	assign strap_idx = 4'(strap_digit(strap_s2_q[3:2]) * 4'h3) + strap_digit(strap_s2_q[1:0]);

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			settle_q <= 2'h0;
			cap_done_q <= 1'b0;
			spi_mode_q <= 1'b0;
			own_addr_q <= 7'h0;
		end
		else if (!cap_done_q && settle_q != STRAP_SETTLE)
			settle_q <= settle_q + 2'h1;
		else if (!cap_done_q)
		begin
			cap_done_q <= 1'b1;
			spi_mode_q <= (strap_idx == 4'h0);
			own_addr_q <= {BASE_ADDR, 3'(strap_idx - 4'h1)};
		end
	end

	// ==========================================================
	// byte engine
	i2cfol_state_t state_q;
	i2cfol_kind_t kind_q;
	i2cfol_kind_t kind_c;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic id_armed_q;
	logic id_mode_q;
	logic [1:0] tx_idx_q;
	logic tx_next_q;
	logic sda_oen_q;
	logic rd_req_q;
	logic first_q;
	logic push_q;
	i2cfol_rx_t push_data_q;
	logic buf_ready;
	logic ack_c;
	logic tx_c;
	logic arm_c;
	logic [7:0] id_nxt;

	assign id_nxt = id_byte(tx_idx_q + 2'h1);

	// decision at the end of each received byte
	always_comb
	begin
		ack_c = 1'b0;
		tx_c = 1'b0;
		arm_c = id_armed_q;
		kind_c = K_DATA;
		case (kind_q)
			K_ADDR:
			begin
				if (shift_q == ID_WR_BYTE)
				begin
					ack_c = 1'b1;
					kind_c = K_IDSEL;
				end
				else if (shift_q == ID_RD_BYTE)
				begin
					ack_c = id_armed_q;
					tx_c = 1'b1;
				end
				else if (shift_q[7:1] == own_addr_q)
				begin
					ack_c = 1'b1;
					tx_c = shift_q[0];
					arm_c = 1'b0;
				end
				else
					arm_c = 1'b0;
			end
			K_IDSEL:
			begin
				ack_c = (shift_q[7:1] == own_addr_q);
				arm_c = ack_c;
				kind_c = K_IDSEL;
			end
			default:
				ack_c = buf_ready; // full buffer nacks so no byte is lost silently
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			state_q <= ST_IDLE;
			kind_q <= K_ADDR;
			cnt_q <= 4'h0;
			shift_q <= 8'h0;
			id_armed_q <= 1'b0;
			id_mode_q <= 1'b0;
			tx_idx_q <= 2'h0;
			tx_next_q <= 1'b0;
			sda_oen_q <= 1'b1;
			rd_req_q <= 1'b0;
			first_q <= 1'b0;
			push_q <= 1'b0;
			push_data_q <= '0;
		end
		else
		begin
			rd_req_q <= 1'b0;
			push_q <= 1'b0;
			if (spi_mode_q || !cap_done_q)
			begin
				state_q <= ST_IDLE;
				sda_oen_q <= 1'b1;
			end
			else if (bus_stop)
			begin
				state_q <= ST_IDLE;
				id_armed_q <= 1'b0;
				id_mode_q <= 1'b0;
				sda_oen_q <= 1'b1;
			end
			else if (bus_start)
			begin
				state_q <= ST_RX;
				kind_q <= K_ADDR;
				cnt_q <= 4'h0;
				first_q <= 1'b1;
				id_mode_q <= 1'b0;
				sda_oen_q <= 1'b1;
			end
			else if (rd_req_q)
			begin
				shift_q <= rd_data_i;
				sda_oen_q <= rd_data_i[7];
			end
			else
			begin
				case (state_q)
					ST_RX:
					begin
						if (scl_rise)
						begin
							shift_q <= {shift_q[6:0], sda_f};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == BIT_CNT_BYTE)
						begin
							id_armed_q <= arm_c;
							kind_q <= kind_c;
							if (ack_c)
							begin
								state_q <= ST_ACK;
								sda_oen_q <= 1'b0;
								tx_next_q <= tx_c;
								id_mode_q <= (kind_q == K_ADDR) && (shift_q == ID_RD_BYTE);
								push_q <= (kind_q == K_DATA);
								push_data_q <= '{first: first_q, data: shift_q};
								if (kind_q == K_DATA)
									first_q <= 1'b0;
							end
							else
								state_q <= ST_IDLE;
						end
					end
					ST_ACK:
					begin
						if (scl_fall)
						begin
							cnt_q <= 4'h0;
							tx_idx_q <= 2'h0;
							sda_oen_q <= 1'b1;
							if (tx_next_q && id_mode_q)
							begin
								state_q <= ST_TX;
								shift_q <= id_byte(2'h0);
								sda_oen_q <= ID_WORD[23];
							end
							else if (tx_next_q)
							begin
								state_q <= ST_TX;
								rd_req_q <= 1'b1;
							end
							else
								state_q <= ST_RX;
						end
					end
					ST_TX:
					begin
						if (scl_rise)
							cnt_q <= cnt_q + 4'h1;
						else if (scl_fall && cnt_q == BIT_CNT_BYTE)
						begin
							state_q <= ST_MACK;
							sda_oen_q <= 1'b1;
						end
						else if (scl_fall)
						begin
							shift_q <= {shift_q[6:0], 1'b1};
							sda_oen_q <= shift_q[6];
						end
					end
					ST_MACK:
					begin
						if (scl_rise && sda_f)
						begin
							state_q <= ST_IDLE;
							id_armed_q <= 1'b0;
							id_mode_q <= 1'b0;
						end
						else if (scl_rise)
							cnt_q <= BIT_CNT_ACKED;
						else if (scl_fall && cnt_q == BIT_CNT_ACKED)
						begin
							state_q <= ST_TX;
							cnt_q <= 4'h0;
							if (id_mode_q && tx_idx_q == ID_LAST_IDX)
								shift_q <= 8'hff; // past the last byte the line stays released
							else if (id_mode_q)
							begin
								tx_idx_q <= tx_idx_q + 2'h1;
								shift_q <= id_nxt;
								sda_oen_q <= id_nxt[7];
							end
							else
								rd_req_q <= 1'b1;
						end
					end
					default:
						sda_oen_q <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// write byte buffer
	i2cfol_buf2 u_buf (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(push_q),
		.in_data_i(push_data_q),
		.in_ready_o(buf_ready),
		.out_valid_o(rx_valid_o),
		.out_data_o(rx_data_o),
		.out_ready_i(rx_ready_i)
	);

	// open drain: only ever pull low, enable low means driving
	assign sda_o = 1'b0;
	assign sda_oen_o = sda_oen_q;
	assign spi_mode_o = spi_mode_q;
	assign own_addr_o = own_addr_q;
	assign rd_req_o = rd_req_q;

endmodule : i2cfol_top
`default_nettype wire

// ==== tb/i2cfol_asserts.sv ====
// checker for the i2c follower top ports
// assumes it is bound onto i2cfol_top; straps hold still after reset
`timescale 1ns/1ps
`default_nettype none
module i2cfol_chk
	import i2cfol_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// straps and bus
	input wire logic [1:0] addr_strap_low_pin_i,
	input wire logic [1:0] addr_strap_high_pin_i,
	input wire logic scl_i,
	input wire logic sda_oen_o,
	// status and data
	input wire logic spi_mode_o,
	input wire logic [6:0] own_addr_o,
	input wire i2cfol_rx_t rx_data_o,
	input wire logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic rd_req_o,
	input wire logic [7:0] rd_data_i
);
	function automatic logic [3:0] tv(input logic [1:0] c);
		return (c == 2'h2) ? 4'h2 : ((c == 2'h0) ? 4'h0 : 4'h1);
	endfunction : tv
	// ternary strap pair as one number, 0 means spi mode
	logic [3:0] code;
	assign code = 4'(3 * tv(addr_strap_high_pin_i) + tv(addr_strap_low_pin_i));
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// ====================
	// assertions
	AST_SPI_QUIET: assert property (spi_mode_o |-> sda_oen_o && !rd_req_o)
		else $error("bus driven in spi mode");
	AST_SPI_SEL: assert property ($rose(spi_mode_o) |-> code == 4'h0)
		else $error("spi mode with straps not low");
	AST_BASE: assert property (own_addr_o != 7'h0 |-> own_addr_o[6:3] == 4'h8)
		else $error("address base wrong");
	AST_MAP: assert property ($changed(own_addr_o) && !spi_mode_o |-> own_addr_o[2:0] == 3'(code - 4'h1))
		else $error("strap decode wrong");
	// a drive change must follow a real scl low, not a spike
	AST_FILT: assert property ($changed(sda_oen_o) |-> !$past(scl_i, 6))
		else $error("sda moved without scl low");
	AST_RDREQ: assert property (rd_req_o |=> !rd_req_o)
		else $error("read request too long");
	AST_RDBIT: assert property (rd_req_o |-> ##[1:2] sda_oen_o == rd_data_i[7])
		else $error("read msb not driven");
	AST_RXHOLD: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
		else $error("stalled byte lost");
endmodule : i2cfol_chk
bind i2cfol_top i2cfol_chk u_chk (
	.clk_i(clk_i),
	.nrst_i(nrst_i),
	.addr_strap_low_pin_i(addr_strap_low_pin_i),
	.addr_strap_high_pin_i(addr_strap_high_pin_i),
	.scl_i(scl_i),
	.sda_oen_o(sda_oen_o),
	.spi_mode_o(spi_mode_o),
	.own_addr_o(own_addr_o),
	.rx_data_o(rx_data_o),
	.rx_valid_o(rx_valid_o),
	.rx_ready_i(rx_ready_i),
	.rd_req_o(rd_req_o),
	.rd_data_i(rd_data_i)
);
`default_nettype wire

// ==== tb/i2cfol_leader.sv ====
// i2c bus leader model: drives scl, pulls or releases sda
// assumes sda_i is the resolved wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module i2cfol_leader
(
	// clock
	input wire logic clk_i,
	// bus
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// quarter step in core cycles; low phase is 3q so the follower settles first
	int q = 4;
	logic spk = 1'b0;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	// ====================
	// bus conditions, also a repeated start when scl is low
	task automatic start();
		sda_o <= 1'b1;
		wt(2 * q);
		scl_o <= 1'b1;
		wt(2 * q);
		sda_o <= 1'b0;
		wt(2 * q);
		scl_o <= 1'b0;
		wt(q);
	endtask : start
	task automatic stop();
		sda_o <= 1'b0;
		wt(2 * q);
		scl_o <= 1'b1;
		wt(2 * q);
		sda_o <= 1'b1;
		wt(2 * q);
	endtask : stop
	task automatic bit_x(input logic b, output logic r);
		sda_o <= b;
		wt(2 * q);
		scl_o <= 1'b1;
		if (spk)
		begin
			// 30 ns low spike inside the high phase
			wt(q);
			scl_o <= 1'b0;
			wt(3);
			scl_o <= 1'b1;
			// the spike restarts the filter count, so a full high span must follow it
			wt(2 * q);
		end
		else
			wt(2 * q);
		r = sda_i;
		scl_o <= 1'b0;
		wt(q);
	endtask : bit_x
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask : wr
	task automatic rd(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(nack, r);
	endtask : rd
endmodule : i2cfol_leader
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the i2c follower top
// assumes the leader model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	import i2cfol_pkg::*;
	localparam logic [6:0] ADR = 7'h43;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic rx_ready_i = 1'b0;
	logic [1:0] addr_strap_low_pin_i = 2'h1;
	logic [1:0] addr_strap_high_pin_i = 2'h1;
	logic [7:0] rd_data_i = 8'h5a;
	logic scl_i;
	logic ld_sda;
	logic sda_i;
	logic sda_o;
	logic sda_oen_o;
	logic spi_mode_o;
	logic [6:0] own_addr_o;
	i2cfol_rx_t rx_data_o;
	logic rx_valid_o;
	logic rd_req_o;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic a;
	logic [7:0] d;
	assign sda_i = ld_sda & (sda_oen_o | sda_o);
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end
	i2cfol_top DUT (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.addr_strap_low_pin_i(addr_strap_low_pin_i),
		.addr_strap_high_pin_i(addr_strap_high_pin_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oen_o(sda_oen_o),
		.spi_mode_o(spi_mode_o),
		.own_addr_o(own_addr_o),
		.rx_data_o(rx_data_o),
		.rx_valid_o(rx_valid_o),
		.rx_ready_i(rx_ready_i),
		.rd_req_o(rd_req_o),
		.rd_data_i(rd_data_i)
	);
	i2cfol_leader ld (
		.clk_i(clk_i),
		.sda_i(sda_i),
		.scl_o(scl_i),
		.sda_o(ld_sda)
	);
	// ====================
	// helpers
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic wrap_up();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic rst(input logic [1:0] h, input logic [1:0] l);
		@(posedge clk_i);
		addr_strap_high_pin_i <= h;
		addr_strap_low_pin_i <= l;
		nrst_i <= 1'b0;
		ld.wt(6);
		nrst_i <= 1'b1;
		ld.wt(30);
	endtask : rst
	task automatic pop(input i2cfol_rx_t e);
		chk(rx_valid_o === 1'b1 && rx_data_o === e, "rx byte");
		rx_ready_i <= 1'b1;
		@(posedge clk_i);
		rx_ready_i <= 1'b0;
		@(posedge clk_i);
	endtask : pop
	task automatic arm(input logic [6:0] who, input logic exp);
		ld.start();
		ld.wr(8'hf8, a);
		chk(a === 1'b1, "f8");
		ld.wr({who, 1'b1}, a);
		chk(a === exp, "select");
	endtask : arm
	// ====================
	// scenarios
	task automatic t_straps();
		for (int h = 0; h < 3; h++)
			for (int l = 0; l < 3; l++)
			begin
				rst(2'(h), 2'(l));
				if (h + l == 0)
				begin
					chk(spi_mode_o === 1'b1, "spi");
					ld.start();
					ld.wr(8'h80, a);
					chk(a === 1'b0, "ack in spi");
					ld.stop();
				end
				else
					chk(own_addr_o === {4'h8, 3'(3 * h + l - 1)}, "addr");
			end
		rst(2'h1, 2'h1);
	endtask : t_straps
	task automatic t_id(input int nl);
		arm(ADR, 1'b1);
		ld.start();
		ld.wr(8'hf9, a);
		chk(a === 1'b1, "f9");
		for (int k = 0; k <= nl; k++)
		begin
			ld.rd(k == nl, d);
			chk(d === ID_WORD[23 - 8 * k -: 8], "id");
		end
		ld.rd(1'b1, d);
		chk(d === 8'hff, "after nack");
		ld.stop();
	endtask : t_id
	task automatic t_cancel();
		arm(ADR, 1'b1);
		ld.stop();
		ld.start();
		ld.wr(8'hf9, a);
		chk(a === 1'b0, "f9 after stop");
		ld.stop();
		arm(7'h44, 1'b0);
		ld.stop();
		arm(ADR, 1'b1);
		ld.start();
		ld.wr({7'h44, 1'b0}, a);
		chk(a === 1'b0, "other");
		ld.start();
		ld.wr(8'hf9, a);
		chk(a === 1'b0, "f9 after other");
		ld.stop();
	endtask : t_cancel
	task automatic t_write();
		ld.start();
		ld.wr({ADR, 1'b0}, a);
		chk(a === 1'b1, "wr addr");
		ld.wr(8'h11, a);
		ld.wr(8'h22, a);
		chk(a === 1'b1, "data");
		ld.wr(8'h33, a);
		chk(a === 1'b0, "full");
		ld.stop();
		pop({1'b1, 8'h11});
		pop({1'b0, 8'h22});
		chk(rx_valid_o === 1'b0, "empty");
	endtask : t_write
	task automatic t_read();
		ld.start();
		ld.wr({ADR, 1'b0}, a);
		ld.wr(8'h05, a);
		ld.start();
		ld.wr({ADR, 1'b1}, a);
		chk(a === 1'b1, "rd addr");
		ld.rd(1'b0, d);
		rd_data_i <= 8'ha5;
		chk(d === 8'h5a, "rd0");
		ld.rd(1'b1, d);
		chk(d === 8'ha5, "rd1");
		ld.stop();
		pop({1'b1, 8'h05});
	endtask : t_read
	initial
	begin
		t_straps();
		t_id(2);
		t_id(0);
		t_cancel();
		t_write();
		t_read();
		ld.spk = 1'b1;
		t_id(2);
		ld.spk = 1'b0;
		ld.q = 50;
		t_id(2);
		wrap_up();
	end
	// cut a hang short well past the expected run length
	initial
	begin
		repeat (80000) @(posedge clk_i);
		n_mismatch++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
